// File: dv/motion_core_model.sv
// Pedometer and orientation core stand-in for the event logic
`default_nettype none
module motion_core_model (
	// Clock
	input wire logic ref_clk_in,
	// From event logic
	input wire logic tilt_ref_capture_in,
	// To event logic
	output logic step_out,
	output logic tilt_exceed_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int angle = 0;
	int ref_angle = 0;
	initial step_out = 1'b0;
	initial tilt_exceed_out = 1'b0;
	// ****************************************
	// Orientation against last reference
	// ****************************************
	always @(posedge ref_clk_in) begin
		if (tilt_ref_capture_in)
			ref_angle <= angle;
		tilt_exceed_out <= (angle - ref_angle) > 35;
	end
	// ****************************************
	// Commands from the bench
	// ****************************************
	task automatic steps(input int n, input int gap);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk_in);
			step_out <= 1'b1;
			@(posedge ref_clk_in);
			step_out <= 1'b0;
			repeat (gap) @(posedge ref_clk_in);
		end
	endtask
	task automatic set_angle(input int a);
		@(posedge ref_clk_in);
		angle <= a;
	endtask
endmodule
`default_nettype wire

// File: dv/motion_tilt_event_logic_bench.sv
// Self-checking bench of the motion and tilt event logic
`default_nettype none
module motion_tilt_event_logic_bench;
	import motion_event_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// Short counts keep the run small
	localparam int TICK = 100;
	localparam int PULSE = 5;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	reg_req_s req = '0;
	logic [7:0] rd_data;
	logic step, exceed, cap, tick_p, pin;
	int n_fail = 0;
	int samples_checked = 0;
	int rises = 0;
	int caps = 0;
	logic [7:0] exp_q[$];
	logic rd_pend = 1'b0;
	logic rd_cur = 1'b0;
	logic pin_d = 1'b0;

	motion_tilt_event_logic #(.TICK_CYCLES(TICK), .PULSE_CYCLES(PULSE)) dut (
		.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_req_in(req),
		.rd_data_out(rd_data), .step_in(step), .tilt_exceed_in(exceed),
		.tilt_ref_capture_out(cap), .algo_tick_out(tick_p),
		.second_irq_pin_out(pin));
	motion_core_model core (.ref_clk_in(ref_clk_in),
		.tilt_ref_capture_in(cap), .step_out(step),
		.tilt_exceed_out(exceed));

	initial forever #20 ref_clk_in = ~ref_clk_in;
	// ****************************************
	// Watchers
	// ****************************************
	always @(posedge ref_clk_in) begin
		if (pin === 1'b1 && pin_d !== 1'b1)
			rises++;
		pin_d = pin;
		if (cap === 1'b1)
			caps++;
	end
	// Read data lands one cycle after the strobe
	always @(posedge ref_clk_in) begin
		rd_cur = req.rd & ~rst_in;
		if (rd_pend) begin
			#1;
			check_byte(rd_data, exp_q.pop_front());
		end
		rd_pend = rd_cur;
	end
	// ****************************************
	// Compare and report
	// ****************************************
	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check_byte(input logic [7:0] got, input logic [7:0] e);
		samples_checked++;
		if (got !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t read %h expected %h", $time, got, e);
		end
	endtask
	task automatic check_bit(input logic got, input logic e, input string s);
		samples_checked++;
		if (got !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t %s", $time, s);
		end
	endtask
	task automatic check_num(input int got, input int e, input string s);
		samples_checked++;
		if (got != e) begin
			n_fail++;
			$display("MISMATCH t=%0t %s: %0d not %0d", $time, s, got, e);
		end
	endtask
	// ****************************************
	// Register and timing helpers
	// ****************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk_in);
		req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge ref_clk_in);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk_in);
		req <= '0;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic give_up(input string s);
		n_fail++;
		$display("MISMATCH t=%0t waited too long for %s", $time, s);
		summarize();
	endtask
	task automatic wait_pin(input int bound);
		for (int k = 0; pin !== 1'b1; k++) begin
			if (k == bound)
				give_up("pin");
			cyc(1);
		end
	endtask
	task automatic wait_tick(output int k);
		k = 0;
		do begin
			cyc(1);
			k++;
		end while (tick_p !== 1'b1 && k <= 2 * TICK);
		if (k > 2 * TICK)
			give_up("tick");
	endtask
	task automatic high_len(output int n);
		n = 0;
		while (pin === 1'b1 && n < 4 * TICK) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic ticks_to_pin(output int n);
		n = 0;
		for (int k = 0; k < 60 * TICK && pin !== 1'b1; k++) begin
			cyc(1);
			if (tick_p === 1'b1)
				n++;
		end
	endtask
	task automatic do_reset;
		// Lets a read still in flight be checked before reset
		repeat (2) @(posedge ref_clk_in);
		rst_in <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		rises = 0;
		caps = 0;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		int n;
		void'($urandom(17));
		do_reset();
		rd(MOTION_THS_ADDR, 8'h00);
		wr(BANK_ACCESS_ADDR, 8'h10);
		rd(MOTION_THS_ADDR, MOTION_THS_RST);
		rd(STEP_DEBOUNCE_ADDR, STEP_DEBOUNCE_RST);
		wr(MOTION_THS_ADDR, 8'h03);
		rd(MOTION_THS_ADDR, 8'h03);
		wr(BANK_ACCESS_ADDR, 8'h00);
		rd(8'h50, 8'h00);
		wr(PIN2_ROUTE_ADDR, 8'h08);
		core.steps(8, 3);
		cyc(2 * TICK);
		check_num(rises, 0, "disabled motion");
		wr(FUNC_ENABLE_ADDR, 8'h02);
		core.steps(6, $urandom_range(1, 20));
		cyc(2 * TICK);
		check_num(rises, 0, "below debounce count");
		core.steps(1, 0);
		wait_pin(2 * TICK);
		high_len(n);
		check_num(n, PULSE, "motion pin pulse");
		rd(EVENT_STATUS_ADDR, 8'h02);
		cyc(TICK);
		rd(EVENT_STATUS_ADDR, 8'h00);
		// Latched and routed motion
		do_reset();
		wr(IRQ_CONFIG_ADDR, 8'h04);
		wr(PIN2_ROUTE_ADDR, 8'h08);
		wr(FUNC_ENABLE_ADDR, 8'h02);
		core.steps(7, 2);
		wait_pin(2 * TICK);
		cyc(2 * TICK);
		check_bit(pin, 1'b1, "motion latched");
		rd(EVENT_STATUS_ADDR, 8'h02);
		cyc(2);
		check_bit(pin, 1'b0, "motion cleared");
		rd(EVENT_STATUS_ADDR, 8'h00);
		// Latch selected but unrouted motion, status clears on the strobe
		do_reset();
		wr(IRQ_CONFIG_ADDR, 8'h04);
		wr(FUNC_ENABLE_ADDR, 8'h02);
		core.steps(7, 2);
		wait_tick(n);
		cyc(2);
		rd(EVENT_STATUS_ADDR, 8'h02);
		cyc(TICK);
		rd(EVENT_STATUS_ADDR, 8'h00);
		check_num(rises, 0, "unrouted pin");
		wait_tick(n);
		wait_tick(n);
		check_num(n, TICK, "tick period");
		// Tilt
		do_reset();
		wr(PIN2_ROUTE_ADDR, 8'h10);
		core.set_angle(40);
		cyc(3 * TICK);
		check_num(rises, 0, "tilt disabled");
		wr(FUNC_ENABLE_ADDR, 8'h10);
		cyc(4);
		check_num(caps, 1, "reference capture");
		core.set_angle(80);
		ticks_to_pin(n);
		check_num(n, int'(TILT_HOLD_TICKS), "first tilt hold");
		high_len(n);
		check_num(n, PULSE, "tilt pin pulse");
		rd(EVENT_STATUS_ADDR, 8'h04);
		cyc(TICK);
		rd(EVENT_STATUS_ADDR, 8'h00);
		core.set_angle(100);
		cyc(4 * TICK);
		check_num(rises, 1, "small tilt");
		core.set_angle(140);
		ticks_to_pin(n);
		check_num(n, 1, "later tilt");
		high_len(n);
		check_num(n, PULSE, "later tilt pulse");
		wr(IRQ_CONFIG_ADDR, 8'h04);
		core.set_angle(200);
		wait_pin(2 * TICK);
		cyc(TICK);
		check_bit(pin, 1'b1, "tilt latched");
		rd(EVENT_STATUS_ADDR, 8'h04);
		cyc(2);
		check_bit(pin, 1'b0, "tilt cleared");
		// Step detector with debounce off
		do_reset();
		wr(BANK_ACCESS_ADDR, 8'h10);
		wr(STEP_DEBOUNCE_ADDR, 8'h68);
		wr(BANK_ACCESS_ADDR, 8'h00);
		wr(PIN2_ROUTE_ADDR, 8'h04);
		wr(FUNC_ENABLE_ADDR, 8'h01);
		n = $urandom_range(3, 9);
		core.steps(n, $urandom_range(1, 30));
		// Pulses may already be over when the steps end
		cyc(2 * TICK);
		check_bit(rises != 0, 1'b1, "step pin");
		rd(STEP_COUNT_L_ADDR, 8'(n));
		rd(STEP_COUNT_H_ADDR, 8'h00);
		cyc(2);
		summarize();
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge ref_clk_in);
		give_up("end of run");
	end
endmodule
`default_nettype wire

// File: pkg/motion_event_pkg.sv
// Constants, types and register map of the motion and tilt event logic
`default_nettype none
package motion_event_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] BANK_ACCESS_ADDR = 8'h21;
	localparam logic [7:0] IRQ_CONFIG_ADDR = 8'h22;
	localparam logic [7:0] PIN2_ROUTE_ADDR = 8'h24;
	localparam logic [7:0] STEP_DEBOUNCE_ADDR = 8'h2b;
	localparam logic [7:0] MOTION_THS_ADDR = 8'h34;
	localparam logic [7:0] STEP_COUNT_L_ADDR = 8'h3b;
	localparam logic [7:0] STEP_COUNT_H_ADDR = 8'h3c;
	localparam logic [7:0] EVENT_STATUS_ADDR = 8'h3d;
	localparam logic [7:0] FUNC_ENABLE_ADDR = 8'h3f;
	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int unsigned FE_STEP_BIT = 0;
	localparam int unsigned FE_MOTION_BIT = 1;
	localparam int unsigned FE_TILT_BIT = 4;
	localparam int unsigned ROUTE_STEP_BIT = 2;
	localparam int unsigned ROUTE_MOTION_BIT = 3;
	localparam int unsigned ROUTE_TILT_BIT = 4;
	localparam int unsigned LATCH_SELECT_BIT = 2;
	localparam int unsigned BANK_OPEN_BIT = 4;
	localparam int unsigned EV_STEP = 0;
	localparam int unsigned EV_MOTION = 1;
	localparam int unsigned EV_TILT = 2;
	localparam int unsigned EV_N = 3;
	localparam logic [7:0] MOTION_THS_RST = 8'h06;
	localparam logic [7:0] STEP_DEBOUNCE_RST = 8'h6f;
	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned ALGO_HZ = 25;
	localparam int unsigned TICK_CYCLES = CLK_HZ / ALGO_HZ;
	localparam int unsigned PIN_PULSE_NS = 60000;
	localparam int unsigned PIN_PULSE_CYCLES = PIN_PULSE_NS / CLK_PERIOD_NS;
	localparam int unsigned TILT_HOLD_S = 2;
	localparam int unsigned TILT_HOLD_TICKS = TILT_HOLD_S * ALGO_HZ;
	localparam int unsigned DEB_LSB_MS = 80;
	localparam int unsigned DEB_LSB_TICKS = DEB_LSB_MS * ALGO_HZ / 1000;
	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;
	typedef enum logic [2:0] {
		TILT_OFF = 3'b001,
		TILT_FIRST = 3'b010,
		TILT_ARMED = 3'b100
	} tilt_state_e;
endpackage
`default_nettype wire

// File: rtl/motion_tilt_event_logic.sv
// Step, significant motion and tilt event logic with register file
`default_nettype none
module motion_tilt_event_logic #(
	parameter int unsigned TICK_CYCLES = motion_event_pkg::TICK_CYCLES,
	parameter int unsigned PULSE_CYCLES = motion_event_pkg::PIN_PULSE_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Register port
	input wire motion_event_pkg::reg_req_s reg_req_in,
	output logic [7:0] rd_data_out,
	// Pedometer and orientation cores
	input wire logic step_in,
	input wire logic tilt_exceed_in,
	output logic tilt_ref_capture_out,
	output logic algo_tick_out,
	// Interrupt pin
	output logic second_irq_pin_out
);
	import motion_event_pkg::*;

	if (TICK_CYCLES < 4 || PULSE_CYCLES < 1 ||
		PULSE_CYCLES >= TICK_CYCLES) begin : g_bad
		$error("Tick or pulse length out of range");
	end

	localparam int TW = $clog2(TICK_CYCLES);
	localparam int PW = $clog2(PULSE_CYCLES + 1);

	function automatic logic [2:0] pick3(input logic [7:0] r,
		input int unsigned b0, input int unsigned b1, input int unsigned b2);
		return {r[b2], r[b1], r[b0]};
	endfunction

	// ****************************************
	// Algorithm rate strobe
	// ****************************************
	logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
	logic tick;
	assign tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));
	assign algo_tick_out = tick;
	always_comb begin
		tick_cnt_next = tick ? '0 : tick_cnt_reg + TW'(1);
	end
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) tick_cnt_reg <= '0;
		else tick_cnt_reg <= tick_cnt_next;
	end

	// ****************************************
	// Register file
	// ****************************************
	logic [7:0] func_en_reg, func_en_next, route_reg, route_next;
	logic [7:0] irq_cfg_reg, irq_cfg_next, bank_reg, bank_next;
	logic [7:0] ths_reg, ths_next, deb_reg, deb_next;
	logic [7:0] rd_data_reg, rd_data_next;
	logic [15:0] step_cnt_reg;
	logic [2:0] status_reg, en_vec, route_vec, hold_mode, blocked;
	logic bank_open, stat_read, latch;
	assign bank_open = bank_reg[BANK_OPEN_BIT];
	assign latch = irq_cfg_reg[LATCH_SELECT_BIT];
	assign stat_read = reg_req_in.rd &&
		reg_req_in.addr == EVENT_STATUS_ADDR;
	assign en_vec = pick3(func_en_reg, FE_STEP_BIT, FE_MOTION_BIT,
		FE_TILT_BIT);
	assign route_vec = pick3(route_reg, ROUTE_STEP_BIT, ROUTE_MOTION_BIT,
		ROUTE_TILT_BIT);
	assign hold_mode = route_vec & {EV_N{latch}};
	// Latched requests hold off new detection until read
	assign blocked = status_reg & hold_mode;
	assign rd_data_out = rd_data_reg;

	always_comb begin
		func_en_next = func_en_reg;
		route_next = route_reg;
		irq_cfg_next = irq_cfg_reg;
		bank_next = bank_reg;
		ths_next = ths_reg;
		deb_next = deb_reg;
		rd_data_next = rd_data_reg;
		if (reg_req_in.wr) begin
			case (reg_req_in.addr)
				FUNC_ENABLE_ADDR: func_en_next = reg_req_in.wdata;
				PIN2_ROUTE_ADDR: route_next = reg_req_in.wdata;
				IRQ_CONFIG_ADDR: irq_cfg_next = reg_req_in.wdata;
				// Only the bank bit is writable
				BANK_ACCESS_ADDR: bank_next = reg_req_in.wdata &
					(8'h01 << BANK_OPEN_BIT);
				MOTION_THS_ADDR: if (bank_open) begin
					ths_next = reg_req_in.wdata;
				end
				STEP_DEBOUNCE_ADDR: if (bank_open) begin
					deb_next = reg_req_in.wdata;
				end
				default: ;
			endcase
		end
		if (reg_req_in.rd) begin
			case (reg_req_in.addr)
				FUNC_ENABLE_ADDR: rd_data_next = func_en_reg;
				PIN2_ROUTE_ADDR: rd_data_next = route_reg;
				IRQ_CONFIG_ADDR: rd_data_next = irq_cfg_reg;
				BANK_ACCESS_ADDR: rd_data_next = bank_reg;
				MOTION_THS_ADDR:
					rd_data_next = bank_open ? ths_reg : 8'h00;
				STEP_DEBOUNCE_ADDR:
					rd_data_next = bank_open ? deb_reg : 8'h00;
				STEP_COUNT_L_ADDR: rd_data_next = step_cnt_reg[7:0];
				STEP_COUNT_H_ADDR: rd_data_next = step_cnt_reg[15:8];
				EVENT_STATUS_ADDR: rd_data_next = {5'h00, status_reg};
				default: rd_data_next = 8'h00;
			endcase
		end
	end
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			func_en_reg <= 8'h00;
			route_reg <= 8'h00;
			irq_cfg_reg <= 8'h00;
			bank_reg <= 8'h00;
			ths_reg <= MOTION_THS_RST;
			deb_reg <= STEP_DEBOUNCE_RST;
			rd_data_reg <= 8'h00;
		end else begin
			func_en_reg <= func_en_next;
			route_reg <= route_next;
			irq_cfg_reg <= irq_cfg_next;
			bank_reg <= bank_next;
			ths_reg <= ths_next;
			deb_reg <= deb_next;
			rd_data_reg <= rd_data_next;
		end
	end

	// ****************************************
	// Pedometer debounce, step count, motion
	// ****************************************
	logic [2:0] deb_cnt_reg, deb_cnt_next, deb_steps;
	logic [5:0] deb_idle_reg, deb_idle_next, deb_limit;
	logic [15:0] step_cnt_next;
	logic [7:0] mot_cnt_reg, mot_cnt_next, eff_ths;
	logic deb_done_reg, deb_done_next, step_rep;
	logic raw_step, raw_motion, raw_tilt;
	assign deb_steps = deb_reg[2:0];
	assign deb_limit = 6'(deb_reg[7:3] * DEB_LSB_TICKS);
	// Debounce count wins while it exceeds the motion threshold
	assign eff_ths = (deb_steps == 3'h0 || ths_reg >= {5'h00, deb_steps}) ?
		ths_reg : {5'h00, deb_steps};

	always_comb begin
		deb_cnt_next = deb_cnt_reg;
		deb_done_next = deb_done_reg;
		deb_idle_next = deb_idle_reg;
		step_cnt_next = step_cnt_reg;
		mot_cnt_next = mot_cnt_reg;
		step_rep = 1'b0;
		raw_motion = 1'b0;
		if (tick && deb_idle_reg != 6'h3f) deb_idle_next = deb_idle_reg + 6'h01;
		// A long pause restarts the debounce
		if (deb_limit != 6'h00 && deb_idle_reg >= deb_limit) begin
			deb_done_next = 1'b0;
			deb_cnt_next = 3'h0;
		end
		if (step_in && en_vec[EV_STEP]) begin
			deb_idle_next = 6'h00;
			if (deb_done_reg || deb_steps == 3'h0) begin
				step_rep = 1'b1;
			end else if (deb_cnt_reg + 3'h1 >= deb_steps) begin
				step_rep = 1'b1;
				deb_done_next = 1'b1;
				deb_cnt_next = 3'h0;
			end else begin
				deb_cnt_next = deb_cnt_reg + 3'h1;
			end
		end
		if (step_rep) step_cnt_next = step_cnt_reg + 16'h0001;
		if (!en_vec[EV_MOTION]) begin
			mot_cnt_next = 8'h00;
		end else if (step_in && !blocked[EV_MOTION]) begin
			if (mot_cnt_reg + 8'h01 >= eff_ths) begin
				raw_motion = 1'b1;
				mot_cnt_next = 8'h00;
			end else begin
				mot_cnt_next = mot_cnt_reg + 8'h01;
			end
		end
	end
	assign raw_step = step_rep && !blocked[EV_STEP];
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			deb_cnt_reg <= 3'h0;
			deb_done_reg <= 1'b0;
			deb_idle_reg <= 6'h00;
			step_cnt_reg <= 16'h0000;
			mot_cnt_reg <= 8'h00;
		end else begin
			deb_cnt_reg <= deb_cnt_next;
			deb_done_reg <= deb_done_next;
			deb_idle_reg <= deb_idle_next;
			step_cnt_reg <= step_cnt_next;
			mot_cnt_reg <= mot_cnt_next;
		end
	end

	// ****************************************
	// Tilt sequencing
	// ****************************************
	tilt_state_e tilt_reg, tilt_next;
	logic [5:0] hold_reg, hold_next;
	logic cap_reg, cap_next;
	assign tilt_ref_capture_out = cap_reg;

	always_comb begin
		tilt_next = tilt_reg;
		hold_next = hold_reg;
		cap_next = 1'b0;
		raw_tilt = 1'b0;
		if (!en_vec[EV_TILT]) begin
			tilt_next = TILT_OFF;
		end else begin
			unique case (tilt_reg)
				TILT_OFF: begin
					tilt_next = TILT_FIRST;
					hold_next = 6'h00;
					cap_next = 1'b1;
				end
				TILT_FIRST: if (tick && !blocked[EV_TILT]) begin
					if (!tilt_exceed_in) begin
						hold_next = 6'h00;
					end else if (hold_reg == 6'(TILT_HOLD_TICKS - 1)) begin
						raw_tilt = 1'b1;
						tilt_next = TILT_ARMED;
						cap_next = 1'b1;
					end else begin
						hold_next = hold_reg + 6'h01;
					end
				end
				TILT_ARMED: if (tick && tilt_exceed_in && !blocked[EV_TILT]) begin
					raw_tilt = 1'b1;
					cap_next = 1'b1;
				end
				default: tilt_next = TILT_OFF;
			endcase
		end
	end
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tilt_reg <= TILT_OFF;
			hold_reg <= 6'h00;
			cap_reg <= 1'b0;
		end else begin
			tilt_reg <= tilt_next;
			hold_reg <= hold_next;
			cap_reg <= cap_next;
		end
	end

	// ****************************************
	// Event status and interrupt pin
	// ****************************************
	logic [2:0] raw_ev, fire, pend_reg, pend_next, status_next;
	logic [PW-1:0] pulse_reg, pulse_next;
	logic pin_reg, pin_next;
	assign raw_ev = {raw_tilt, raw_motion, raw_step};
	// Events wait for the strobe so unlatched status lasts exactly one period
	assign fire = tick ? (pend_reg | raw_ev) : 3'h0;
	assign second_irq_pin_out = pin_reg;

	always_comb begin
		pend_next = tick ? 3'h0 : (pend_reg | raw_ev);
		status_next = status_reg;
		for (int i = 0; i < EV_N; i++) begin
			if (fire[i]) begin
				status_next[i] = 1'b1;
			end else if (hold_mode[i] ? stat_read : tick) begin
				status_next[i] = 1'b0;
			end
		end
		pulse_next = pulse_reg;
		if (|(fire & route_vec & ~hold_mode)) begin
			pulse_next = PW'(PULSE_CYCLES);
		end else if (pulse_reg != '0) begin
			pulse_next = pulse_reg - PW'(1);
		end
		pin_next = (|(status_next & hold_mode)) || pulse_next != '0;
	end
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pend_reg <= 3'h0;
			status_reg <= 3'h0;
			pulse_reg <= '0;
			pin_reg <= 1'b0;
		end else begin
			pend_reg <= pend_next;
			status_reg <= status_next;
			pulse_reg <= pulse_next;
			pin_reg <= pin_next;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	// Counts against both limits, not against the selected one
	a_motion_count_ok: assert property (raw_motion |->
		mot_cnt_reg + 8'h01 >= ths_reg &&
		mot_cnt_reg + 8'h01 >= {5'h00, deb_steps})
		else $error("Motion event before threshold");
	a_motion_enable: assert property (!en_vec[EV_MOTION] |->
		!raw_motion)
		else $error("Motion event while disabled");
	a_motion_status: assert property ((fire[EV_MOTION] &&
		!hold_mode[EV_MOTION]) |=> status_reg[EV_MOTION] &&
		(!route_vec[EV_MOTION] || second_irq_pin_out))
		else $error("Motion event not shown");
	a_pin_pulse_len: assert property ((fire[EV_MOTION] &&
		route_vec[EV_MOTION] && !latch) |=>
		pulse_reg == PW'(PULSE_CYCLES))
		else $error("Pin pulse length wrong");
	a_latch_read_clear: assert property ((stat_read &&
		blocked[EV_MOTION] && !fire[EV_MOTION] &&
		$stable(hold_mode)) |=> !status_reg[EV_MOTION])
		else $error("Latched motion not cleared");
	a_status_one_tick: assert property ((tick &&
		status_reg[EV_MOTION] && !hold_mode[EV_MOTION] &&
		!fire[EV_MOTION]) |=> !status_reg[EV_MOTION])
		else $error("Status pulse outlived period");
	a_ths_bank_gate: assert property ((reg_req_in.wr &&
		reg_req_in.addr == MOTION_THS_ADDR && !bank_open) |=>
		$stable(ths_reg))
		else $error("Threshold written with bank closed");
	a_ths_select: assert property ((deb_steps != 3'h0 &&
		ths_reg < {5'h00, deb_steps}) |->
		eff_ths == {5'h00, deb_steps})
		else $error("Debounce count not governing");
	a_tilt_enable: assert property (!en_vec[EV_TILT] |=>
		tilt_reg == TILT_OFF)
		else $error("Tilt active while disabled");
	a_tilt_first_hold: assert property ((raw_tilt &&
		tilt_reg == TILT_FIRST) |->
		hold_reg == 6'(TILT_HOLD_TICKS - 1) && tick)
		else $error("First tilt too early");
	a_tilt_capture: assert property (raw_tilt |=>
		tilt_ref_capture_out)
		else $error("Reference not captured");
	a_step_count: assert property (step_rep |=>
		step_cnt_reg == $past(step_cnt_reg) + 16'h0001)
		else $error("Step total not advanced");

	c_motion_fire: cover property (fire[EV_MOTION]);
	c_tilt_armed: cover property (tilt_reg == TILT_ARMED ##1 raw_tilt);
	c_latch_clear: cover property (blocked[EV_TILT] && stat_read);
	c_pin_pulse: cover property ($fell(second_irq_pin_out));
endmodule
`default_nettype wire
